// *** abu_hysteresis.v ***
`timescale 1ns/1ps
module abu_hysteresis
(
    clk,
    rst_n,
    restart,
    sampleValid,
    angleIn,
    windowWidth,
    filtAngle,
    turnDir
);
    input  wire        clk;
    input  wire        rst_n;
    input  wire        restart;
    input  wire        sampleValid;
    input  wire [13:0] angleIn;
    input  wire [5:0]  windowWidth;
    output wire [13:0] filtAngle;
    output wire        turnDir;

    reg  [13:0] head_reg;
    reg         dir_reg;
    reg         seeded_reg;
    wire [13:0] delta;
    wire [13:0] negDelta;
    wire [13:0] width14;
    wire        fwdMove;
    wire        backOut;

    assign delta    = angleIn - head_reg;
    assign negDelta = head_reg - angleIn;
    assign width14  = {8'h00, windowWidth};
    // window measured in 14-bit lsb units
    assign fwdMove  = dir_reg ? (negDelta != 14'h0000 && !negDelta[13])
                              : (delta != 14'h0000 && !delta[13]);
    assign backOut  = dir_reg ? (!delta[13] && delta > width14)
                              : (!negDelta[13] && negDelta > width14);
    assign filtAngle = head_reg;
    assign turnDir   = dir_reg;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            head_reg   <= 14'h0000;
            dir_reg    <= 1'b0;
            seeded_reg <= 1'b0;
        end
        else if (restart)
        begin
            dir_reg    <= 1'b0;
            seeded_reg <= 1'b0;
        end
        else if (sampleValid)
        begin
            if (!seeded_reg)
            begin
                head_reg   <= angleIn;
                seeded_reg <= 1'b1;
            end
            else if (fwdMove)
            begin
                head_reg <= angleIn;
            end
            else if (backOut)
            begin
                head_reg <= angleIn;
                dir_reg  <= ~dir_reg;
            end
            // otherwise hold inside window
        end
    end
endmodule

// *** abu_map.vh ***
// Contract
// - index output goes high at the absolute zero angle position
// - index pulse width selectable among four options
// - pole-pair count 1 to 16 from 4-bit code, count equals code plus one
// - without hysteresis, commutation outputs switch as raw angle crosses transitions
// - with hysteresis in use, commutation follows the filtered angle
// - quadrature and index outputs carry no meaning during the power-on interval
// - delay phase after power-on shows zero angle: A and B low, index high
// - then outputs step the shorter way to the angle at the slew rate
// - slew time zero skips catch-up and jumps straight to measured position
// - hysteresis window is field value times 360/16384 degrees, 14-bit resolution
// - routing bit set makes quadrature, index and commutation use filtered angle
// - filtered angle readable at 12-bit resolution regardless of routing
// - filtered output follows the angle directly while moving in reference direction
// - on reversal the filtered output holds until angle leaves the window
// - leaving on the far side moves the head there and flips direction
// - direction flag reads 0 for increasing and 1 for decreasing
// - power-up and self-test reset direction to increasing, window behind angle
// - quadrature follows gray order 00,01,11,10 upward, reverse downward
// - nonzero slew time steps valid states at most once per slew interval
`ifndef ABU_MAP_VH
`define ABU_MAP_VH
`define ABU_CTRL_ADDR     8'h00
`define ABU_SLEW_ADDR     8'h04
`define ABU_HYST_ADDR     8'h08
`define ABU_STAT_ADDR     8'h0c
`define ABU_FILT_ADDR     8'h10
`define ABU_ANGLE_ADDR    8'h14
`define ABU_RES_LSB       0
`define ABU_PP_LSB        4
`define ABU_IDXW_LSB      8
`define ABU_ROUTE_BIT     10
`define ABU_CTRL_RESET    16'h000e
`define ABU_SLEW_RESET    16'h0000
`define ABU_HYST_RESET    6'h00
`define ABU_CLK_NS        20
`define ABU_TICK_NS       1000
`define ABU_TICK_CYC      (`ABU_TICK_NS / `ABU_CLK_NS)
`define ABU_PON_NS        10000
`define ABU_PON_CYC       ((`ABU_PON_NS + `ABU_CLK_NS - 1) / `ABU_CLK_NS)
`define ABU_DELAY_NS      10000
`define ABU_DELAY_CYC     ((`ABU_DELAY_NS + `ABU_CLK_NS - 1) / `ABU_CLK_NS)
`endif

// *** abu_output.v ***
`timescale 1ns/1ps
`include "abu_map.vh"
module abu_output
#(
    parameter PON_CYC   = `ABU_PON_CYC,
    parameter DELAY_CYC = `ABU_DELAY_CYC
)
(
    ref_clk,
    rst_n,
    wb_cyc_i,
    wb_stb_i,
    wb_we_i,
    wb_adr_i,
    wb_sel_i,
    wb_dat_i,
    wb_dat_o,
    wb_ack_o,
    angleIn,
    angleValid,
    selfTestDone,
    quadA,
    quadB,
    quadIndex,
    phaseU,
    phaseV,
    phaseW,
    turnDirectionFlag
);
    input  wire        ref_clk;
    input  wire        rst_n;
    input  wire        wb_cyc_i;
    input  wire        wb_stb_i;
    input  wire        wb_we_i;
    input  wire [7:0]  wb_adr_i;
    input  wire [3:0]  wb_sel_i;
    input  wire [31:0] wb_dat_i;
    output reg  [31:0] wb_dat_o;
    output reg         wb_ack_o;
    input  wire [13:0] angleIn;
    input  wire        angleValid;
    input  wire        selfTestDone;
    output reg         quadA;
    output reg         quadB;
    output reg         quadIndex;
    output reg         phaseU;
    output reg         phaseV;
    output reg         phaseW;
    output wire        turnDirectionFlag;

    localparam S_PON   = 2'd0;
    localparam S_DELAY = 2'd1;
    localparam S_CATCH = 2'd2;
    localparam S_RUN   = 2'd3;
    localparam TICK_LAST = `ABU_TICK_CYC - 1;
    // quadrature resolution code to right shift of the 14-bit angle
    function [3:0] resShift;
        input [3:0] code;
        begin
            if (code < 4'd3 || code > 4'd14)
                resShift = 4'd12;
            else
                resShift = code - 4'd2;
        end
    endfunction
    // byte-lane merge for 16-bit registers
    function [15:0] laneMerge;
        input [15:0] old;
        input [15:0] nw;
        input [1:0]  sel;
        begin
            laneMerge = {sel[1] ? nw[15:8] : old[15:8],
                         sel[0] ? nw[7:0] : old[7:0]};
        end
    endfunction
    reg  [15:0] ctrl_reg;
    reg  [15:0] slew_reg;
    reg  [5:0]  hyst_reg;
    reg  [13:0] angle_reg;
    reg         sampled_reg;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [15:0] phaseCnt_reg;
    reg  [5:0]  tickCnt_reg;
    reg         tick_reg;
    reg  [15:0] slewCnt_reg;
    reg  [12:0] qpos_reg;
    reg  [12:0] qpos_next;
    reg  [2:0]  uvw_next;
    reg  [31:0] readMux;
    wire        busReq;
    wire        wrDone;
    wire [3:0]  resCode;
    wire [4:0]  polePairs;
    wire [1:0]  idxSel;
    wire        routeFilt;
    wire [13:0] filtAngle;
    wire [13:0] selAngle;
    wire [3:0]  shift;
    wire [12:0] mask;
    wire [12:0] tpos;
    wire [12:0] diff;
    wire        stepDown;
    wire        stepOk;
    wire        matched;
    wire [18:0] elecProd;
    wire [13:0] elecAngle;
    wire [16:0] sectorProd;
    wire [2:0]  sector;
    wire        restart;
    wire        stepNow;
    assign resCode   = ctrl_reg[`ABU_RES_LSB +: 4];
    assign polePairs = {1'b0, ctrl_reg[`ABU_PP_LSB +: 4]} + 5'd1;
    assign idxSel    = ctrl_reg[`ABU_IDXW_LSB +: 2];
    assign routeFilt = ctrl_reg[`ABU_ROUTE_BIT];
    assign restart   = selfTestDone;

    abu_hysteresis u_hyst
    (
        .clk         (ref_clk),
        .rst_n       (rst_n),
        .restart     (restart),
        .sampleValid (angleValid),
        .angleIn     (angleIn),
        .windowWidth (hyst_reg),
        .filtAngle   (filtAngle),
        .turnDir     (turnDirectionFlag)
    );

    // angle source for both output kinds
    assign selAngle = routeFilt ? filtAngle : angle_reg;
    assign shift    = resShift(resCode);
    assign mask     = 13'h1fff >> (shift - 4'd1);
    assign tpos     = selAngle[13:1] >> (shift - 4'd1);
    assign diff     = (tpos - qpos_reg) & mask;
    assign stepDown = |(diff & ~(mask >> 1));
    assign matched  = (diff == 13'h0000);
    assign stepOk   = (slewCnt_reg >= slew_reg);
    assign stepNow  = (state_reg == S_CATCH || state_reg == S_RUN) && stepOk && !matched;
    assign elecProd   = {5'b00000, selAngle} * {14'h0000, polePairs};
    assign elecAngle  = elecProd[13:0];
    assign sectorProd = {3'b000, elecAngle} * 17'd6;
    assign sector     = sectorProd[16:14];
    // wishbone classic slave
    assign busReq = wb_cyc_i && wb_stb_i;
    assign wrDone = busReq && wb_we_i && wb_ack_o;

    always @*
    begin
        readMux = 32'h00000000;
        if (wb_adr_i == `ABU_CTRL_ADDR)
            readMux = {16'h0000, ctrl_reg};
        else if (wb_adr_i == `ABU_SLEW_ADDR)
            readMux = {16'h0000, slew_reg};
        else if (wb_adr_i == `ABU_HYST_ADDR)
            readMux = {26'h0000000, hyst_reg};
        else if (wb_adr_i == `ABU_STAT_ADDR)
            readMux = {22'h000000, quadIndex, quadB, quadA, phaseW, phaseV,
                       phaseU, state_reg, matched, turnDirectionFlag};
        else if (wb_adr_i == `ABU_FILT_ADDR)
            readMux = {20'h00000, filtAngle[13:2]};
        else if (wb_adr_i == `ABU_ANGLE_ADDR)
            readMux = {18'h00000, angle_reg};
    end
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else if (wb_ack_o)
            wb_ack_o <= 1'b0;
        else if (busReq)
        begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= readMux;
        end
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= `ABU_CTRL_RESET;
            slew_reg <= `ABU_SLEW_RESET;
            hyst_reg <= `ABU_HYST_RESET;
        end
        else if (wrDone)
        begin
            if (wb_adr_i == `ABU_CTRL_ADDR)
                ctrl_reg <= laneMerge(ctrl_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
            else if (wb_adr_i == `ABU_SLEW_ADDR)
                slew_reg <= laneMerge(slew_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
            else if (wb_adr_i == `ABU_HYST_ADDR && wb_sel_i[0])
                hyst_reg <= wb_dat_i[5:0];
        end
    end

    // latest raw sample
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            angle_reg   <= 14'h0000;
            sampled_reg <= 1'b0;
        end
        else if (restart)
            sampled_reg <= 1'b0;
        else if (angleValid)
        begin
            angle_reg   <= angleIn;
            sampled_reg <= 1'b1;
        end
    end

    // 1 us tick and slew interval counter
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tickCnt_reg <= 6'd0;
            tick_reg    <= 1'b0;
        end
        else
        begin
            tickCnt_reg <= (stepNow || tickCnt_reg == TICK_LAST[5:0]) ? 6'd0
                                                                    : tickCnt_reg + 6'd1;
            tick_reg    <= !stepNow && tickCnt_reg == TICK_LAST[5:0];
        end
    end
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            slewCnt_reg <= 16'h0000;
        else if (stepNow)
            slewCnt_reg <= 16'h0000;
        else if (tick_reg && slewCnt_reg != 16'hffff)
            slewCnt_reg <= slewCnt_reg + 16'h0001;
    end

    // start-up sequence
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            S_PON:
                if (phaseCnt_reg >= PON_CYC[15:0] - 16'h0001)
                    state_next = S_DELAY;
            S_DELAY:
                if (phaseCnt_reg >= DELAY_CYC[15:0] - 16'h0001 && sampled_reg)
                    state_next = S_CATCH;
            S_CATCH:
                if (slew_reg == 16'h0000 || matched)
                    state_next = S_RUN;
            default:
                state_next = S_RUN;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg    <= S_PON;
            phaseCnt_reg <= 16'h0000;
        end
        else if (restart)
        begin
            state_reg    <= S_PON;
            phaseCnt_reg <= 16'h0000;
        end
        else
        begin
            state_reg <= state_next;
            if (state_next != state_reg)
                phaseCnt_reg <= 16'h0000;
            else if (phaseCnt_reg != 16'hffff)
                phaseCnt_reg <= phaseCnt_reg + 16'h0001;
        end
    end

    // quadrature position tracking
    always @*
    begin
        qpos_next = qpos_reg;
        case (state_reg)
            S_PON, S_DELAY:
                qpos_next = 13'h0000;
            default:
                if (slew_reg == 16'h0000)
                    qpos_next = tpos;
                else if (stepOk && !matched)
                begin
                    if (stepDown)
                        qpos_next = (qpos_reg - 13'h0001) & mask;
                    else
                        qpos_next = (qpos_reg + 13'h0001) & mask;
                end
        endcase
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            qpos_reg <= 13'h0000;
        else if (restart)
            qpos_reg <= 13'h0000;
        else
            qpos_reg <= qpos_next;
    end

    // gray outputs and index from the tracked position
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            quadA     <= 1'b0;
            quadB     <= 1'b0;
            quadIndex <= 1'b0;
        end
        else if (state_reg == S_PON || restart)
        begin
            quadA     <= 1'b0;
            quadB     <= 1'b0;
            quadIndex <= 1'b0;
        end
        else
        begin
            quadA     <= qpos_next[1];
            quadB     <= qpos_next[1] ^ qpos_next[0];
            quadIndex <= (qpos_next <= {11'h000, idxSel});
        end
    end

    // commutation sectors of 60 electrical degrees
    always @*
    begin
        case (sector)
            3'd0: uvw_next = 3'b100;
            3'd1: uvw_next = 3'b110;
            3'd2: uvw_next = 3'b010;
            3'd3: uvw_next = 3'b011;
            3'd4: uvw_next = 3'b001;
            default: uvw_next = 3'b101;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phaseU <= 1'b0;
            phaseV <= 1'b0;
            phaseW <= 1'b0;
        end
        else if (sampled_reg)
        begin
            phaseU <= uvw_next[2];
            phaseV <= uvw_next[1];
            phaseW <= uvw_next[0];
        end
    end
endmodule

// *** abu_output_props.sv ***
`timescale 1ns/1ps
module abu_output_props
#(
    parameter PON_CYC   = 8,
    parameter DELAY_CYC = 8
)
(
    input wire        ref_clk,
    input wire        rst_n,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        angleValid,
    input wire        selfTestDone,
    input wire        quadA,
    input wire        quadB,
    input wire        quadIndex,
    input wire        phaseU,
    input wire        phaseV,
    input wire        phaseW,
    input wire        turnDirectionFlag
);
    logic [7:0] phaseCnt;
    logic [3:0] sinceEv;
    wire        evt = angleValid || selfTestDone || (wb_ack_o && wb_we_i);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // cycles since reset release, parked once a self-test restart happens
    always_ff @(posedge ref_clk or negedge rst_n)
        if (!rst_n)
        begin
            phaseCnt <= 8'h00;
            sinceEv  <= 4'hf;
        end
        else
        begin
            phaseCnt <= (selfTestDone || phaseCnt == 8'hff) ? 8'hff : phaseCnt + 8'h01;
            sinceEv  <= evt ? 4'h0 : (sinceEv == 4'hf ? sinceEv : sinceEv + 4'h1);
        end

    a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_unmapped_read: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
        && wb_adr_i >= 8'h18 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_pon_quiet: assert property (phaseCnt >= 1 && phaseCnt < PON_CYC - 1
        |-> !quadA && !quadB && !quadIndex)
        else $error("outputs active in power-on interval");
    a_delay_zero: assert property (phaseCnt >= PON_CYC + 2
        && phaseCnt < PON_CYC + DELAY_CYC - 1 |-> !quadA && !quadB && quadIndex)
        else $error("delay phase not showing zero angle");
    a_dir_start: assert property (phaseCnt < PON_CYC |-> !turnDirectionFlag)
        else $error("direction not increasing after reset");
    a_dir_restart: assert property (selfTestDone |-> ##[1:3] !turnDirectionFlag)
        else $error("direction not cleared by self-test");
    a_dir_cause: assert property ($changed(turnDirectionFlag) |-> sinceEv <= 4'd4)
        else $error("direction changed without a sample");
    a_phase_cause: assert property ($changed({phaseU, phaseV, phaseW}) |-> sinceEv <= 4'd4)
        else $error("commutation changed without a sample");

    c_delay: cover property (phaseCnt == PON_CYC + 3);
    c_dir_flip: cover property ($rose(turnDirectionFlag));
    c_restart: cover property (selfTestDone);
endmodule

bind abu_output abu_output_props #(.PON_CYC(PON_CYC), .DELAY_CYC(DELAY_CYC)) abu_output_props_inst
(
    .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .angleValid(angleValid), .selfTestDone(selfTestDone), .quadA(quadA), .quadB(quadB),
    .quadIndex(quadIndex), .phaseU(phaseU), .phaseV(phaseV), .phaseW(phaseW),
    .turnDirectionFlag(turnDirectionFlag)
);

// *** abu_output_tb_top.sv ***
`timescale 1ns/1ps
`include "abu_map.vh"
`define ABU_CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module abu_output_tb_top;
    localparam int PON = 8;
    localparam int DLY = 8;
    logic        ref_clk = 0;
    logic        rst_n = 0;
    logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0]  wb_adr_i = 0;
    logic [3:0]  wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, monM, monE, tmp;
    logic        wb_ack_o, angleValid = 0, selfTestDone = 0, armed = 0;
    logic [13:0] angleIn = 0;
    logic        quadA, quadB, quadIndex, phaseU, phaseV, phaseW, turnDirectionFlag;
    logic [31:0] expQ[$], maskQ[$];
    int          stepCount, badSteps, minGap, failures = 0, comparisons = 0, cycles = 0;
    int          seed = 32'h8991bcaa;
    int          hAng[5] = '{4100, 4090, 4080, 4096, 4097};
    int          hFilt[5] = '{1025, 1025, 1020, 1020, 1024};
    int          hB[5] = '{1, 1, 0, 0, 1};
    int          hDir[5] = '{0, 0, 1, 1, 0};

    abu_output #(.PON_CYC(PON), .DELAY_CYC(DLY)) abu_output_inst
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .angleIn(angleIn), .angleValid(angleValid),
        .selfTestDone(selfTestDone), .quadA(quadA), .quadB(quadB), .quadIndex(quadIndex),
        .phaseU(phaseU), .phaseV(phaseV), .phaseW(phaseW),
        .turnDirectionFlag(turnDirectionFlag)
    );
    abu_quad_rx abu_quad_rx_inst
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .armed(armed), .quadA(quadA), .quadB(quadB),
        .stepCount(stepCount), .badSteps(badSteps), .minGap(minGap)
    );

    always #10 ref_clk = ~ref_clk;

    task automatic tally_and_finish;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= 4'h3;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        bus(1'b1, adr, d, tmp);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] m, input logic [31:0] e);
        maskQ.push_back(m);
        expQ.push_back(e);
        bus(1'b0, adr, 32'h0, tmp);
    endtask

    task automatic peek(input logic [7:0] adr, output logic [31:0] d);
        maskQ.push_back(32'h0);
        expQ.push_back(32'h0);
        bus(1'b0, adr, 32'h0, d);
    endtask

    task automatic ang(input int a);
        @(posedge ref_clk);
        angleIn <= a[13:0];
        angleValid <= 1'b1;
        @(posedge ref_clk);
        angleValid <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask

    function automatic logic [31:0] st(input logic a, input logic b, input logic i);
        return {22'h0, i, b, a, 7'h0};
    endfunction

    // read results are compared against the oldest note
    always @(posedge ref_clk)
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && maskQ.size() > 0)
        begin
            monM = maskQ.pop_front();
            monE = expQ.pop_front();
            if (monM != 32'h0)
                `ABU_CHK(wb_dat_o & monM, monE)
        end

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            tally_and_finish;
        end
    end

    initial
    begin
        int k;
        logic [31:0] d0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (PON + DLY + 4) @(posedge ref_clk);
        rd(`ABU_STAT_ADDR, 32'h381, 32'h200);
        rd(`ABU_CTRL_ADDR, 32'h7ff, 32'h00e);
        rd(`ABU_SLEW_ADDR, 32'hffff, 32'h0);
        rd(`ABU_HYST_ADDR, 32'h3f, 32'h0);
        wr(8'h20, 32'hffff);
        rd(8'h20, 32'hffffffff, 32'h0);
        for (int w = 0; w < 4; w++)
            for (int p = 0; p < 4; p++)
            begin
                wr(`ABU_CTRL_ADDR, (w << 8) | 32'h00e);
                ang((p << 12) | ($random(seed) & 32'hfff));
                rd(`ABU_STAT_ADDR, 32'h380, st(p[1], p[1] ^ p[0], p <= w));
            end
        for (int c = 0; c < 16; c += 5)
        begin
            k = $unsigned($random(seed)) % 6;
            wr(`ABU_CTRL_ADDR, (c << 4) | 32'h00e);
            ang((k * 2731 + 1365) / (c + 1));
            peek(`ABU_STAT_ADDR, d0);
            `ABU_CHK(d0[6:4] == 3'b000 || d0[6:4] == 3'b111, 1'b0)
            ang(((k * 2731 + 1365 + 8192) % 16384) / (c + 1));
            rd(`ABU_STAT_ADDR, 32'h70, ~d0 & 32'h70);
        end
        wr(`ABU_CTRL_ADDR, 32'h00d);
        ang(32'h0100);
        wr(`ABU_SLEW_ADDR, 32'h2);
        armed <= 1'b1;
        ang(32'h1900);
        repeat (450) @(posedge ref_clk);
        rd(`ABU_STAT_ADDR, 32'h182, 32'h082);
        `ABU_CHK(stepCount, 3)
        ang(32'h0100);
        repeat (450) @(posedge ref_clk);
        rd(`ABU_STAT_ADDR, 32'h182, 32'h002);
        `ABU_CHK(stepCount, 0)
        `ABU_CHK(badSteps, 0)
        `ABU_CHK(minGap >= 2 * 50 - 1, 1'b1)
        armed <= 1'b0;
        wr(`ABU_CTRL_ADDR, 32'h40e);
        wr(`ABU_HYST_ADDR, 32'h10);
        ang(4000);
        for (int i = 0; i < 5; i++)
        begin
            ang(hAng[i]);
            repeat (150) @(posedge ref_clk);
            rd(`ABU_FILT_ADDR, 32'hfff, hFilt[i]);
            rd(`ABU_STAT_ADDR, 32'h181, st(1'b0, hB[i][0], 1'b0) | hDir[i]);
        end
        ang(4070);
        rd(`ABU_STAT_ADDR, 32'h1, 32'h1);
        @(posedge ref_clk);
        selfTestDone <= 1'b1;
        @(posedge ref_clk);
        selfTestDone <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(`ABU_STAT_ADDR, 32'h1, 32'h0);
        repeat (PON) @(posedge ref_clk);
        rd(`ABU_STAT_ADDR, 32'h380, 32'h200);
        tally_and_finish;
    end
endmodule

// *** abu_quad_rx.sv ***
`timescale 1ns/1ps
module abu_quad_rx
(
    input  wire ref_clk,
    input  wire rst_n,
    input  wire armed,
    input  wire quadA,
    input  wire quadB,
    output int  stepCount,
    output int  badSteps,
    output int  minGap
);
    logic [1:0] lastPos;
    int         gap;
    wire  [1:0] pos = {quadA, quadA ^ quadB};

    // counts gray steps and the shortest spacing between them while armed
    always @(posedge ref_clk or negedge rst_n)
        if (!rst_n)
        begin
            lastPos <= 2'h0;
            gap <= 10000;
            minGap <= 10000;
            stepCount <= 0;
            badSteps <= 0;
        end
        else if (!armed)
        begin
            lastPos <= pos;
            gap <= 10000;
            minGap <= 10000;
        end
        else
        begin
            gap <= gap + 1;
            if (pos != lastPos)
            begin
                if (pos - lastPos == 2'd1)
                    stepCount <= stepCount + 1;
                else if (pos - lastPos == 2'd3)
                    stepCount <= stepCount - 1;
                else
                    badSteps <= badSteps + 1;
                if (gap < minGap)
                    minGap <= gap;
                gap <= 1;
                lastPos <= pos;
            end
        end
endmodule
